// File: inc/alu_flags_consts.svh
`ifndef ALU_FLAGS_CONSTS_SVH
`define ALU_FLAGS_CONSTS_SVH
`define FLAGS_OFFSET      4'h0
`define OPCODE_OFFSET     4'h4
`define OPERAND_A_OFFSET  4'h8
`define OPERAND_B_OFFSET  4'hC
`define RESULT_OFFSET     5'h10
`define CARRY_BIT         0
`define NIBBLE_CARRY_BIT  1
`define ZERO_BIT          2
`define OVERFLOW_BIT      3
`define NEGATIVE_BIT      4
`define FLAG_MASK         8'h1F
`define FLAGS_RESET       8'h00
`endif

// File: inc/alu_flags_pkg.sv
`default_nettype none
package alu_flags_pkg;
  typedef enum logic [3:0] {
    op_add_accumulator_to_file,
    op_add_literal_to_accumulator,
    op_subtract_from_literal,
    op_subtract_accumulator_from_file,
    op_logic_and,
    op_clear_file_instruction,
    op_bit_clear_instruction,
    op_bit_set_instruction,
    op_nibble_swap_instruction,
    op_file_to_file_move,
    op_accumulator_to_file_move,
    op_write_file
  } alu_op_e;
endpackage
`default_nettype wire

// File: rtl/alu_flag_calc.sv
`default_nettype none
`include "alu_flags_consts.svh"
module alu_flag_calc
  import alu_flags_pkg::*;
(
  // Operation
  input  wire alu_flags_pkg::alu_op_e op,
  input  wire logic [7:0]             operand_a,
  input  wire logic [7:0]             operand_b,
  input  wire logic [2:0]             bit_sel,
  input  wire logic [4:0]             flags_in,
  // Results
  output logic [7:0]                  result,
  output logic [4:0]                  flags_out,
  output logic                        flags_touched
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic       arith;
  logic       cin;
  always_comb
  begin
    arith = 1'b0;
    cin = 1'b0;
    addend = operand_b;
    result = operand_a;
    flags_out = flags_in;
    flags_touched = 1'b0;
    case (op)
      op_add_accumulator_to_file, op_add_literal_to_accumulator:
        arith = 1'b1;
      op_subtract_from_literal, op_subtract_accumulator_from_file:
      begin
        arith = 1'b1;
        addend = ~operand_b;
        cin = 1'b1;
      end
      default:
        arith = 1'b0;
    endcase
    // Carry-in keeps both carries and the sign test right for any operand
    sum = {1'b0, operand_a} + {1'b0, addend} + {8'h00, cin};
    low_sum = {1'b0, operand_a[3:0]} + {1'b0, addend[3:0]}
              + {4'h0, cin};
    case (op)
      op_logic_and:
        result = operand_a & operand_b;
      op_clear_file_instruction:
        result = 8'h00;
      op_bit_clear_instruction:
        result = operand_a & ~(8'h01 << bit_sel);
      op_bit_set_instruction:
        result = operand_a | (8'h01 << bit_sel);
      op_nibble_swap_instruction:
        result = {operand_a[3:0], operand_a[7:4]};
      op_file_to_file_move, op_accumulator_to_file_move, op_write_file:
        result = operand_b;
      default:
        result = sum[7:0];
    endcase
    if (arith)
    begin
      flags_touched = 1'b1;
      flags_out[`CARRY_BIT] = sum[8];
      flags_out[`NIBBLE_CARRY_BIT] = low_sum[4];
      flags_out[`OVERFLOW_BIT] = (operand_a[7] == addend[7])
                                 && (sum[7] != operand_a[7]);
      flags_out[`NEGATIVE_BIT] = sum[7];
      flags_out[`ZERO_BIT] = (sum[7:0] == 8'h00);
    end
    else if (op == op_logic_and)
    begin
      flags_touched = 1'b1;
      flags_out[`NEGATIVE_BIT] = result[7];
      flags_out[`ZERO_BIT] = (result == 8'h00);
    end
    else if (op == op_clear_file_instruction)
    begin
      flags_touched = 1'b1;
      flags_out[`ZERO_BIT] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: rtl/alu_status_flags.sv
`default_nettype none
`include "alu_flags_consts.svh"
module alu_status_flags
  import alu_flags_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Flag view
  output logic [7:0]       flags_out
);
  import alu_flags_pkg::*;

  // Flags are not reset: their power-up value is undefined
  logic [4:0]  flags_reg;
  logic [4:0]  flags_next;
  logic [3:0]  opcode_reg;
  logic [3:0]  opcode_next;
  logic        dest_flags_reg;
  logic        dest_flags_next;
  logic [2:0]  bitsel_reg;
  logic [2:0]  bitsel_next;
  logic [7:0]  opa_reg;
  logic [7:0]  opa_next;
  logic [7:0]  opb_reg;
  logic [7:0]  opb_next;
  logic [7:0]  result_reg;
  logic [7:0]  result_next;
  logic        ack_reg;
  logic        ack_next;
  logic        waitreq_reg;
  logic        waitreq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0]  view_reg;
  logic [7:0]  view_next;

  // Datapath and decode
  logic [7:0]  calc_result;
  logic [4:0]  calc_flags;
  logic        calc_touched;
  logic        req;
  logic        wr_go;
  logic        b0;
  logic        b1;
  logic        flag_sel;
  logic        cmd_sel;
  logic        exec_go;
  logic [4:0]  dest_flags;
  logic [7:0]  opa_eff;

  assign req      = (avs_read | avs_write) & ~ack_reg;
  assign wr_go    = avs_write & ~ack_reg;
  assign b0       = avs_byteenable[0];
  assign b1       = avs_byteenable[1];
  assign flag_sel = (avs_address == 5'(`FLAGS_OFFSET));
  assign cmd_sel  = (avs_address == 5'(`OPCODE_OFFSET));
  // Second cycle of an opcode write, while waitrequest is low
  assign exec_go  = ack_reg & avs_write & cmd_sel;

  // Flag register as source operand reads like any register
  assign opa_eff = dest_flags_reg ? {3'b000, flags_reg} : opa_reg;

  alu_flag_calc alu_flag_calc_inst (
    .op            (alu_op_e'(opcode_reg)),
    .operand_a     (opa_eff),
    .operand_b     (opb_reg),
    .bit_sel       (bitsel_reg),
    .flags_in      (flags_reg),
    .result        (calc_result),
    .flags_out     (calc_flags),
    .flags_touched (calc_touched)
  );

  // Flag register as destination: flag-setting ops write their flags, others write the result
  always_comb
  begin
    dest_flags = flags_reg;
    if (calc_touched)
      dest_flags = calc_flags;
    else
      dest_flags = calc_result[4:0] & 5'(`FLAG_MASK);
  end

  // Bus handshake: every access waits one cycle, then answers for one
  // A held request is not taken twice: ack_reg masks it
  always_comb
  begin
    ack_next = 1'b0;
    waitreq_next = 1'b1;
    if (req)
    begin
      ack_next = 1'b1;
      waitreq_next = 1'b0;
    end
  end

  // Waitrequest from its own flop so the port has no gate behind it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ack_reg     <= 1'b0;
      waitreq_reg <= 1'b1;
    end
    else
    begin
      ack_reg     <= ack_next;
      waitreq_reg <= waitreq_next;
    end
  end

  // Read data captured as the read is taken, held until the next access
  always_comb
  begin
    rdata_next = rdata_reg;
    if (req)
    begin
      rdata_next = 32'h0000_0000;
      if (avs_read)
      begin
        case (avs_address)
          5'(`FLAGS_OFFSET):
            rdata_next = {27'h0, flags_reg};
          // Command word reads back as written, except bit 7 and bits 31:9, which read as zero
          5'(`OPCODE_OFFSET):
            rdata_next = {23'h0, dest_flags_reg, 1'b0, bitsel_reg,
                          opcode_reg};
          5'(`OPERAND_A_OFFSET):
            rdata_next = {24'h0, opa_reg};
          5'(`OPERAND_B_OFFSET):
            rdata_next = {24'h0, opb_reg};
          `RESULT_OFFSET:
            rdata_next = {24'h0, result_reg};
          // Unmapped addresses read as zero
          default:
            rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Operands load while the write waits; other addresses leave them
  always_comb
  begin
    opa_next = opa_reg;
    opb_next = opb_reg;
    if (wr_go && b0)
    begin
      case (avs_address)
        5'(`OPERAND_A_OFFSET):
          opa_next = avs_writedata[7:0];
        5'(`OPERAND_B_OFFSET):
          opb_next = avs_writedata[7:0];
        default:
        begin
          opa_next = opa_reg;
          opb_next = opb_reg;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      opa_reg <= 8'h00;
      opb_reg <= 8'h00;
    end
    else
    begin
      opa_reg <= opa_next;
      opb_reg <= opb_next;
    end
  end

  // Command word: opcode and bit select in lane 0, destination in lane 1
  always_comb
  begin
    opcode_next = opcode_reg;
    bitsel_next = bitsel_reg;
    dest_flags_next = dest_flags_reg;
    if (wr_go && cmd_sel)
    begin
      if (b0)
      begin
        opcode_next = avs_writedata[3:0];
        bitsel_next = avs_writedata[6:4];
      end
      if (b1)
        dest_flags_next = avs_writedata[8];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      opcode_reg     <= 4'h0;
      bitsel_reg     <= 3'h0;
      dest_flags_reg <= 1'b0;
    end
    else
    begin
      opcode_reg     <= opcode_next;
      bitsel_reg     <= bitsel_next;
      dest_flags_reg <= dest_flags_next;
    end
  end

  // Executes one cycle after the opcode is loaded, from the new command
  always_comb
  begin
    result_next = result_reg;
    if (exec_go)
      result_next = calc_result;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      result_reg <= 8'h00;
    end
    else
    begin
      result_reg <= result_next;
    end
  end

  // Bus write and execution never meet: they need different addresses
  always_comb
  begin
    flags_next = flags_reg;
    if (wr_go && b0 && flag_sel)
      flags_next = avs_writedata[4:0];
    if (exec_go)
    begin
      if (dest_flags_reg)
        flags_next = dest_flags;
      else if (calc_touched)
        flags_next = calc_flags;
    end
  end

  // No reset on purpose: software must not rely on a start value
  always_ff @(posedge core_clk)
  begin
    flags_reg <= flags_next;
  end

  // Flag view trails the register by one cycle
  always_comb
  begin
    view_next = {3'b000, flags_reg};
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      view_reg <= `FLAGS_RESET;
    end
    else
    begin
      view_reg <= view_next;
    end
  end

  assign avs_waitrequest = waitreq_reg;
  assign avs_readdata    = rdata_reg;
  assign flags_out       = view_reg;
endmodule
`default_nettype wire

// File: test/alu_status_flags_assertions.sv
`default_nettype none
module alu_status_flags_checker
  import alu_flags_pkg::*;
(
  // Watched ports
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic       armed_reg;
  logic       armed_next;
  logic [4:0] wd_reg;
  logic [4:0] wd_next;
  logic       acc_wr;
  // Flags are unknown until software first writes them
  always_comb
  begin
    acc_wr = avs_write && !avs_waitrequest;
    armed_next = armed_reg | (acc_wr && avs_address == 5'h00);
    wd_next = (acc_wr && avs_address == 5'h00) ? avs_writedata[4:0] : wd_reg;
    if (sys_rst)
      armed_next = 1'b0;
  end
  always_ff @(posedge core_clk)
  begin
    armed_reg <= armed_next;
    wd_reg <= wd_next;
  end
  sequence s_flag_wr;
    acc_wr && avs_address == 5'h00;
  endsequence
  sequence s_clear_flags;
    acc_wr && avs_address == 5'h04 && avs_writedata[8]
      && avs_writedata[3:0] == 4'(op_clear_file_instruction);
  endsequence
  a_accept_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest late");
  a_idle_wait_high: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low when idle");
  a_view_upper_zero: assert property (
    flags_out[7:5] == 3'h0) else $error("flag view upper bits set");
  a_read_upper_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == 5'h00
      |-> avs_readdata[7:5] == 3'h0) else $error("flag read upper bits set");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest
      && (avs_address > 5'h10 || avs_address[1:0] != 2'h0)
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_flag_write_lands: assert property (
    s_flag_wr |-> ##[1:2] flags_out[4:0] == wd_reg)
    else $error("flag write lost");
  a_clear_sets_zero: assert property (
    s_clear_flags |-> ##[1:2] flags_out[2]) else $error("clear left zero low");
  a_flags_hold_idle: assert property (
    armed_reg && !avs_write |=> ##1 $stable(flags_out))
    else $error("flags moved without write");
endmodule
bind alu_status_flags alu_status_flags_checker alu_status_flags_checker_inst (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .flags_out(flags_out)
);
`default_nettype wire

// File: test/core_bus_model.sv
`default_nettype none
module core_bus_model (
  // Clock
  input  wire logic        core_clk,
  // Avalon master side
  output logic [4:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  // Starts on a fresh edge so back-to-back calls never clash
  task automatic put(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic get(input logic [4:0] a, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/alu_status_flags_tb.sv
`default_nettype none
module alu_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alu_flags_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  flags_out;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  always #20 core_clk = ~core_clk;
  alu_status_flags alu_status_flags_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flags_out(flags_out));
  core_bus_model core_bus_model_inst (.core_clk(core_clk),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string w, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic run(input int op, input logic [2:0] bs, input logic dst);
    core_bus_model_inst.put(5'h04, {23'h0, dst, 1'b0, bs, 4'(op)});
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    core_bus_model_inst.get(a, q);
    cmp("register", e, q[7:0]);
  endtask
  // Subtract adds the inverted operand plus one, so carry means no borrow
  function automatic logic [7:0] ref_flags(input logic [7:0] a, b,
                                           input logic sb);
    logic [7:0] m;
    logic [8:0] s;
    logic [4:0] h;
    m = sb ? ~b : b;
    s = {1'b0, a} + {1'b0, m} + {8'h0, sb};
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, sb};
    return {3'h0, s[7], a[7] == m[7] && s[7] != a[7], s[7:0] == 8'h0,
            h[4], s[8]};
  endfunction
  task automatic t_regs();
    core_bus_model_inst.put(5'h00, 32'hFF);
    rd(5'h00, 8'h1F);
    rd(5'h14, 8'h00);
  endtask
  task automatic t_arith();
    // Last pair subtracts 80h: sign, overflow and full-borrow corners, with no low-nibble borrow
    logic [7:0] av[5] = '{8'h7F, 8'hFF, 8'h00, 8'h80, 8'h00};
    logic [7:0] bv[5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h80};
    for (int i = 0; i < 5; i++)
    begin
      core_bus_model_inst.put(5'h08, {24'h0, av[i]});
      core_bus_model_inst.put(5'h0C, {24'h0, bv[i]});
      run(i > 3 ? 3 : i, 3'h0, 1'b0);
      rd(5'h00, ref_flags(av[i], bv[i], i > 1));
      rd(5'h10, av[i] + (i > 1 ? ~bv[i] + 8'h01 : bv[i]));
    end
  endtask
  task automatic t_protect();
    core_bus_model_inst.put(5'h00, 32'h0A);
    run(op_clear_file_instruction, 3'h0, 1'b1);
    rd(5'h00, 8'h0E);
    run(op_bit_set_instruction, 3'h0, 1'b1);
    rd(5'h00, 8'h0F);
    run(op_bit_clear_instruction, 3'h2, 1'b1);
    rd(5'h00, 8'h0B);
    core_bus_model_inst.put(5'h08, 32'h80);
    core_bus_model_inst.put(5'h0C, 32'hFF);
    run(op_logic_and, 3'h0, 1'b0);
    rd(5'h00, 8'h1B);
    core_bus_model_inst.put(5'h0C, 32'hE5);
    run(op_add_accumulator_to_file, 3'h0, 1'b1);
    rd(5'h00, 8'h07);
    for (int k = 8; k < 12; k++)
    begin
      run(k, 3'h1, 1'b0);
      rd(5'h00, 8'h07);
    end
    core_bus_model_inst.put(5'h14, 32'hFF);
    rd(5'h00, 8'h07);
    @(negedge core_clk);
    cmp("flag view", 8'h07, flags_out);
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    // Whole run needs under two hundred cycles
    if (cycles == 3000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_arith();
    t_protect();
    tally_and_finish();
  end
endmodule
`default_nettype wire
